// File: hdl/mst_pkg.sv
// Notes on behaviour
// - the slot count is eight bits and drops by one on each prescaler edge
// - the expiry flag is set when the slot count counts down to zero
// - with tick_gen_mode clear the count holds at zero instead of wrapping
// - with tick_gen_mode set the count wraps from zero to all ones
// - with the interrupt enable set, the irq flag pulses as the expiry flag sets
// - an interrupt request needs both the local and the cpu side enable
// - a write to the count register loads the counter at once
// - a count write on a prescaler edge stores the written value minus one
// - the 18-bit prescaler counts up to a top set by its upper eight bits
// - the rate field makes a slot last prescale value times 64, 128, 256 or 1024 ticks
// - every timer event is aligned to the system tick pulse
// - the expiry dma trigger pulses whenever the expiry flag is set
// - waking from deep sleep returns all three registers to reset
// - writing one to the expiry flag leaves it unchanged
// - without free running, the prescaler runs only while the count is nonzero, from null
// - in free running mode the prescaler runs always, starting from null when set while the count is zero
// - a prescale value of zero counts as a multiplier of 256
package mst_pkg;

	// ==================================================
	// register addresses on the special function bus
	localparam logic [7:0] SLOT_COUNT_ADDR   = 8'h9C;
	localparam logic [7:0] PRESCALE_MAX_ADDR = 8'h9D;
	localparam logic [7:0] SLOT_CTL_ADDR     = 8'h9E;

	// ==================================================
	// values after reset
	localparam logic [7:0] SLOT_COUNT_RESET   = 8'h00;
	localparam logic [7:0] PRESCALE_MAX_RESET = 8'h00;
	localparam logic [7:0] SLOT_CTL_RESET     = 8'h00;
	localparam logic [7:0] READ_UNMAPPED      = 8'h00;

	// ==================================================
	// control field positions
	localparam int EXPIRY_BIT   = 6;
	localparam int INT_EN_BIT   = 4;
	localparam int TICK_GEN_BIT = 2;

	// ==================================================
	// prescaler shape
	localparam int PRESCALE_WIDTH = 18;
	localparam int PRESCALE_SHIFT = 10;
	localparam logic [18:0] PRESCALE_FULL = 19'h4_0000;
	localparam logic [7:0] COUNT_ONE  = 8'h01;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_WRAP = 8'hFF;

	// control register layout, reserved bits kept at zero
	typedef struct packed {
		logic       reserved7;
		logic       expiry;
		logic       reserved5;
		logic       intEnable;
		logic       reserved3;
		logic       tickGenMode;
		logic [1:0] prescaleRate;
	} mst_ctl_type;

	// one access from the core
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} mst_sfr_req_type;

	// which register an address hits
	typedef struct packed {
		logic ctl;
		logic pre;
		logic cnt;
	} mst_sel_type;

	// address decode shared by reads and writes
	function automatic mst_sel_type mst_decode(input logic [7:0] addr);
		mst_sel_type sel;
		sel.ctl = (addr == SLOT_CTL_ADDR);
		sel.pre = (addr == PRESCALE_MAX_ADDR);
		sel.cnt = (addr == SLOT_COUNT_ADDR);
		return sel;
	endfunction : mst_decode

	// prescaler increment per tick: 1024 / multiplier
	function automatic logic [17:0] mst_step(input logic [1:0] rate);
		logic [17:0] step;
		step = 18'h0_0001;
		case (rate)
			2'b00: step = 18'h0_0010; // 64
			2'b01: step = 18'h0_0008; // 128
			2'b10: step = 18'h0_0004; // 256
			2'b11: step = 18'h0_0001; // 1024
			default: step = 18'h0_0001;
		endcase
		return step;
	endfunction : mst_step

endpackage : mst_pkg

// File: hdl/mst_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module mst_prescaler #(
	parameter int WIDTH = 18
) (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       hold,
	input  wire logic       tickPulse,
	input  wire logic [1:0] prescaleRate,
	input  wire logic [7:0] prescaleMax,
	output logic            activeEdge
);
	import mst_pkg::*;

	logic [WIDTH-1:0] count;
	logic [WIDTH:0]   sum;
	logic [WIDTH:0]   top;

	// top of count: upper eight bits from the register, zero means 256
	always_comb
	begin
		sum = {1'b0, count} + (WIDTH + 1)'(mst_step(prescaleRate));
		if (prescaleMax == 8'h00)
			top = (WIDTH + 1)'(PRESCALE_FULL);
		else
			top = (WIDTH + 1)'({prescaleMax, {PRESCALE_SHIFT{1'b0}}});
	end

	// counts on ticks only, restarts from null when held
	always_ff @(posedge clock)
	begin
		if (rst || hold)
		begin
			count      <= '0;
			activeEdge <= 1'b0;
		end
		else if (tickPulse)
		begin
			if (sum >= top)
			begin
				count      <= '0;
				activeEdge <= 1'b1;
			end
			else
			begin
				count      <= sum[WIDTH-1:0];
				activeEdge <= 1'b0;
			end
		end
		else
			activeEdge <= 1'b0;
	end

endmodule : mst_prescaler
`default_nettype wire

// File: hdl/mst_timer.sv
`timescale 1ns/1ps
`default_nettype none
module mst_timer (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     deepSleepWake,
	input  wire logic                     tickPulse,
	input  wire mst_pkg::mst_sfr_req_type sfrReq,
	output logic [7:0]                    sfrRdata,
	input  wire logic                     slotIrqCpuEnable,
	output logic                          slotIrqFlag,
	output logic                          irqRequest,
	output logic                          expiryDmaTrigger
);
	import mst_pkg::*;

	// ==================================================
	// state

	mst_ctl_type ctl;
	logic [7:0]  slotCount;
	logic [7:0]  prescaleMax;
	logic [7:0]  next_slotCount;
	logic        resetAll;
	logic        activeEdge;
	logic        tickRun;
	logic        expiryEvent;
	mst_sel_type sel;
	logic        wrCtl;
	logic        wrPre;
	logic        wrCnt;

	// ==================================================
	// decode and common terms

	// wake from deep sleep acts like a reset of the registers
	assign resetAll = rst || deepSleepWake;

	// address decode of the current access
	assign sel   = mst_decode(sfrReq.addr);
	assign wrCtl = sfrReq.wr && sel.ctl;
	assign wrPre = sfrReq.wr && sel.pre;
	assign wrCnt = sfrReq.wr && sel.cnt;

	// prescaler runs while counting or free running
	assign tickRun = ctl.tickGenMode || (slotCount != COUNT_ZERO);

	// ==================================================
	// prescaler

	// held in its null state whenever the tick generator is stopped
	mst_prescaler #(
		.WIDTH        (PRESCALE_WIDTH)
	) prescaler (
		.clock        (clock),
		.rst          (resetAll),
		.hold         (!tickRun),
		.tickPulse    (tickPulse),
		.prescaleRate (ctl.prescaleRate),
		.prescaleMax  (prescaleMax),
		.activeEdge   (activeEdge)
	);

	// ==================================================
	// slot counter

	// next count from a write, an edge, or both
	always_comb
	begin
		next_slotCount = slotCount;
		expiryEvent    = 1'b0;
		if (wrCnt)
		begin
			if (activeEdge)
			begin
				next_slotCount = sfrReq.wdata - COUNT_ONE;
				expiryEvent    = (sfrReq.wdata == COUNT_ONE);
			end
			else
				next_slotCount = sfrReq.wdata;
		end
		else if (activeEdge)
		begin
			if (slotCount == COUNT_ZERO)
			begin
				if (ctl.tickGenMode)
					next_slotCount = COUNT_WRAP;
				else
					next_slotCount = COUNT_ZERO;
			end
			else
			begin
				next_slotCount = slotCount - COUNT_ONE;
				expiryEvent    = (slotCount == COUNT_ONE);
			end
		end
	end

	// count register
	always_ff @(posedge clock)
	begin
		if (resetAll)
			slotCount <= SLOT_COUNT_RESET;
		else
			slotCount <= next_slotCount;
	end

	// ==================================================
	// control and prescale registers

	// prescale multiplier register
	always_ff @(posedge clock)
	begin
		if (resetAll)
			prescaleMax <= PRESCALE_MAX_RESET;
		else if (wrPre)
			prescaleMax <= sfrReq.wdata;
	end

	// writable control fields, reserved bits always zero, expiry set wins over a clearing write
	always_ff @(posedge clock)
	begin
		if (resetAll)
		begin
			ctl.reserved7    <= SLOT_CTL_RESET[7];
			ctl.expiry       <= SLOT_CTL_RESET[EXPIRY_BIT];
			ctl.reserved5    <= SLOT_CTL_RESET[5];
			ctl.reserved3    <= SLOT_CTL_RESET[3];
			ctl.intEnable    <= SLOT_CTL_RESET[INT_EN_BIT];
			ctl.tickGenMode  <= SLOT_CTL_RESET[TICK_GEN_BIT];
			ctl.prescaleRate <= SLOT_CTL_RESET[1:0];
		end
		else
		begin
			ctl.reserved7 <= 1'b0;
			ctl.reserved5 <= 1'b0;
			ctl.reserved3 <= 1'b0;
			if (wrCtl)
			begin
				ctl.intEnable    <= sfrReq.wdata[INT_EN_BIT];
				ctl.tickGenMode  <= sfrReq.wdata[TICK_GEN_BIT];
				ctl.prescaleRate <= sfrReq.wdata[1:0];
			end
			if (expiryEvent)
				ctl.expiry <= 1'b1;
			else if (wrCtl && !sfrReq.wdata[EXPIRY_BIT])
				ctl.expiry <= 1'b0;
			else
				ctl.expiry <= ctl.expiry;
		end
	end

	// ==================================================
	// event outputs

	// one-cycle pulses in the cycle the expiry flag shows set
	always_ff @(posedge clock)
	begin
		if (resetAll)
		begin
			slotIrqFlag      <= 1'b0;
			irqRequest       <= 1'b0;
			expiryDmaTrigger <= 1'b0;
		end
		else
		begin
			slotIrqFlag      <= expiryEvent && ctl.intEnable;
			irqRequest       <= expiryEvent && ctl.intEnable && slotIrqCpuEnable;
			expiryDmaTrigger <= expiryEvent;
		end
	end

	// ==================================================
	// read port

	// registered read data, unmapped addresses read zero
	always_ff @(posedge clock)
	begin
		if (rst)
			sfrRdata <= READ_UNMAPPED;
		else if (sfrReq.rd)
		begin
			if (sel.ctl)
				sfrRdata <= ctl;
			else if (sel.pre)
				sfrRdata <= prescaleMax;
			else if (sel.cnt)
				sfrRdata <= slotCount;
			else
				sfrRdata <= READ_UNMAPPED;
		end
	end

	// ==================================================
	// checks

	default clocking cb @(posedge clock);
	endclocking

	default disable iff (rst || deepSleepWake);

	a_count_decrement: assert property (
		activeEdge && !wrCnt && slotCount != COUNT_ZERO
		|=> slotCount == $past(slotCount) - COUNT_ONE
	) else $error("slot count did not drop by one on an edge");

	a_expiry_sets: assert property (
		activeEdge && !wrCnt && slotCount == COUNT_ONE
		|=> ctl.expiry && slotCount == COUNT_ZERO
	) else $error("expiry flag not set when count reached zero");

	a_hold_at_zero: assert property (
		!ctl.tickGenMode && slotCount == COUNT_ZERO && !wrCnt
		|=> slotCount == COUNT_ZERO
	) else $error("count left zero without free running");

	a_wrap_all_ones: assert property (
		activeEdge && !wrCnt && slotCount == COUNT_ZERO && ctl.tickGenMode
		|=> slotCount == COUNT_WRAP
	) else $error("count did not wrap to all ones");

	a_irq_flag_pulse: assert property (
		expiryEvent
		|=> slotIrqFlag == $past(ctl.intEnable) && ctl.expiry
	) else $error("irq flag does not follow expiry and enable");

	a_irq_needs_both: assert property (
		irqRequest
		|-> slotIrqFlag && $past(slotIrqCpuEnable) && $past(ctl.intEnable)
	) else $error("interrupt request without both enables");

	a_write_loads: assert property (
		wrCnt && !activeEdge
		|=> slotCount == $past(sfrReq.wdata)
	) else $error("count write not loaded");

	a_write_on_edge: assert property (
		wrCnt && activeEdge
		|=> slotCount == $past(sfrReq.wdata) - COUNT_ONE
	) else $error("count write on edge not reduced by one");

	a_edge_on_tick: assert property (
		activeEdge |-> $past(tickPulse)
	) else $error("prescaler edge not aligned to a tick");

	a_dma_with_flag: assert property (
		expiryDmaTrigger |-> ctl.expiry && $past(expiryEvent) ##1 !expiryDmaTrigger || expiryEvent
	) else $error("dma trigger without expiry");

	a_wake_resets: assert property (
		@(posedge clock) disable iff (rst)
		deepSleepWake |=> slotCount == SLOT_COUNT_RESET && ctl == SLOT_CTL_RESET
			&& prescaleMax == PRESCALE_MAX_RESET
	) else $error("registers not reset after deep sleep wake");

	a_write_one_keeps: assert property (
		wrCtl && sfrReq.wdata[EXPIRY_BIT] && !ctl.expiry && !expiryEvent
		|=> !ctl.expiry
	) else $error("writing one changed the expiry flag");

	a_stopped_no_edge: assert property (
		!tickRun ##1 !tickRun |-> !activeEdge
	) else $error("prescaler edge while tick generator stopped");

	a_free_runs: assert property (
		ctl.tickGenMode && slotCount == COUNT_ZERO && activeEdge && !wrCnt
		|=> slotCount == COUNT_WRAP ##1 tickRun
	) else $error("free running tick generator stopped");

	a_clear_flag: assert property (
		wrCtl && !sfrReq.wdata[EXPIRY_BIT] && !expiryEvent
		|=> !ctl.expiry
	) else $error("writing zero did not clear the expiry flag");

	a_set_wins: assert property (
		wrCtl && !sfrReq.wdata[EXPIRY_BIT] && expiryEvent
		|=> ctl.expiry
	) else $error("clearing write beat a same-cycle expiry");

	a_count_still: assert property (
		!activeEdge && !wrCnt
		|=> slotCount == $past(slotCount)
	) else $error("slot count moved without an edge or a write");

	a_dma_one_cycle: assert property (
		expiryDmaTrigger
		|=> !expiryDmaTrigger
	) else $error("dma trigger longer than one cycle");

	a_dma_from_event: assert property (
		expiryEvent
		|=> expiryDmaTrigger
	) else $error("expiry without a dma trigger");

	a_irq_flag_cause: assert property (
		slotIrqFlag
		|-> expiryDmaTrigger && $past(ctl.intEnable)
	) else $error("irq flag without expiry and enable");

	a_irq_both_on: assert property (
		expiryEvent && ctl.intEnable && slotIrqCpuEnable
		|=> irqRequest
	) else $error("no interrupt request with both enables set");

	a_irq_local_off: assert property (
		expiryEvent && !ctl.intEnable
		|=> !slotIrqFlag && !irqRequest
	) else $error("irq pulse with local enable clear");

	a_reserved_zero: assert property (
		ctl.reserved7 == 1'b0 && ctl.reserved5 == 1'b0 && ctl.reserved3 == 1'b0
	) else $error("reserved control bits not zero");

	a_prescale_load: assert property (
		wrPre
		|=> prescaleMax == $past(sfrReq.wdata)
	) else $error("prescale write not loaded");

	a_mode_load: assert property (
		wrCtl
		|=> ctl.tickGenMode == $past(sfrReq.wdata[TICK_GEN_BIT]) && ctl.prescaleRate == $past(sfrReq.wdata[1:0])
	) else $error("mode or rate write not loaded");

	a_wrap_no_expiry: assert property (
		activeEdge && !wrCnt && slotCount == COUNT_ZERO
		|=> !expiryDmaTrigger
	) else $error("wrap from zero raised an expiry");

	a_edge_while_run: assert property (
		activeEdge
		|-> $past(tickRun)
	) else $error("prescaler edge from a stopped tick generator");

	a_zero_write_quiet: assert property (
		wrCnt && sfrReq.wdata == COUNT_ZERO
		|=> !expiryDmaTrigger
	) else $error("writing zero to the count raised an expiry");

	a_read_count: assert property (
		sfrReq.rd && sel.cnt
		|=> sfrRdata == $past(slotCount)
	) else $error("count read returned wrong data");

	a_read_ctl: assert property (
		sfrReq.rd && sel.ctl
		|=> sfrRdata == $past(ctl)
	) else $error("control read returned wrong data");

endmodule : mst_timer
`default_nettype wire

// File: dv/mst_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// core side model: reads and writes the timer registers
module mst_core_model
(
	input  wire logic                    clock,
	output var mst_pkg::mst_sfr_req_type sfrReq,
	input  wire logic [7:0]              sfrRdata
);
	import mst_pkg::*;

	// idle bus at time zero
	initial sfrReq = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

	// one write strobe, then lines flipped so nothing stale is left
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] val;
		val = (addr == SLOT_CTL_ADDR) ? (data & 8'h57) : data;
		@(posedge clock);
		sfrReq <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: val};
		@(posedge clock);
		sfrReq <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~val};
		#1;
	endtask : wr

	// one read strobe, data taken after the edge that took it
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		sfrReq <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge clock);
		sfrReq <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
		#1;
		data = sfrRdata;
	endtask : rd

endmodule : mst_core_model
`default_nettype wire

// File: dv/mst_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// self-checking bench for the slot timer
module mst_timer_test;
	import mst_pkg::*;

	logic                    clock;
	logic                    rst;
	logic                    deepSleepWake;
	logic                    tickPulse;
	logic                    slotIrqCpuEnable;
	mst_pkg::mst_sfr_req_type sfrReq;
	logic [7:0]              sfrRdata;
	logic                    slotIrqFlag;
	logic                    irqRequest;
	logic                    expiryDmaTrigger;
	logic [7:0]              rdv;
	int                      fails;
	int                      num_checks;
	int                      tickDiv;
	int                      tickCnt;
	int                      n;

	mst_timer DUT (.clock(clock), .rst(rst), .deepSleepWake(deepSleepWake), .tickPulse(tickPulse),
		.sfrReq(sfrReq), .sfrRdata(sfrRdata), .slotIrqCpuEnable(slotIrqCpuEnable),
		.slotIrqFlag(slotIrqFlag), .irqRequest(irqRequest), .expiryDmaTrigger(expiryDmaTrigger));

	mst_core_model core (.clock(clock), .sfrReq(sfrReq), .sfrRdata(sfrRdata));

	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// system tick: one pulse every tickDiv cycles, quiet in reset
	always @(posedge clock)
	begin
		if (rst)
		begin
			tickCnt   <= 0;
			tickPulse <= 1'b0;
		end
		else
		begin
			tickCnt   <= (tickCnt + 1 >= tickDiv) ? 0 : tickCnt + 1;
			tickPulse <= (tickCnt + 1 >= tickDiv);
		end
	end

	// ==================================================
	// shared helpers
	task automatic check(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// count cycles until the dma pulse, bounded
	task automatic wait_expiry(input int limit, output int cnt);
		cnt = 0;
		while (expiryDmaTrigger !== 1'b1 && cnt < limit)
		begin
			@(posedge clock);
			#1;
			cnt++;
		end
		if (cnt >= limit)
		begin
			fails++;
			$display("[ERR] %0t no expiry pulse", $time);
			test_done();
		end
	endtask : wait_expiry

	// no pulse may appear for a while
	task automatic quiet(input int cycles);
		logic seen;
		seen = 1'b0;
		repeat (cycles)
		begin
			@(posedge clock);
			#1;
			seen = seen | expiryDmaTrigger | slotIrqFlag;
		end
		check(seen === 1'b0, "pulse while stopped");
	endtask : quiet

	// ==================================================
	// scenarios
	task automatic t_reset();
		core.rd(SLOT_COUNT_ADDR, rdv);
		check(rdv === SLOT_COUNT_RESET, "count reset");
		core.rd(PRESCALE_MAX_ADDR, rdv);
		check(rdv === PRESCALE_MAX_RESET, "prescale reset");
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv === SLOT_CTL_RESET, "control reset");
		core.rd(8'h00, rdv);
		check(rdv === READ_UNMAPPED, "unmapped read");
	endtask : t_reset

	// one slot from count 1, then stop, flag set, clear rules
	task automatic t_slot(input logic [1:0] rate, input logic [7:0] pre, input int ticks, input logic ie);
		int exp;
		exp = ticks * tickDiv;
		core.wr(SLOT_CTL_ADDR, {3'b000, ie, 2'b00, rate});
		core.wr(PRESCALE_MAX_ADDR, pre);
		core.wr(SLOT_COUNT_ADDR, COUNT_ONE);
		wait_expiry(exp + 50, n);
		check(n >= exp && n <= exp + 2 * tickDiv + 3, "slot length");
		check(slotIrqFlag === ie, "irq flag pulse");
		check(irqRequest === (ie & slotIrqCpuEnable), "irq request");
		core.rd(SLOT_COUNT_ADDR, rdv);
		check(rdv === COUNT_ZERO, "count at zero");
		quiet(100);
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv[EXPIRY_BIT] === 1'b1, "expiry flag set");
		core.wr(SLOT_CTL_ADDR, 8'h40);
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv === 8'h40, "write one keeps flag");
		core.wr(SLOT_CTL_ADDR, 8'h00);
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv === 8'h00, "write zero clears flag");
	endtask : t_slot

	// collisions timed from the count write: 64 ticks per slot, one tick per cycle
	task automatic t_collide();
		core.wr(PRESCALE_MAX_ADDR, 8'h01);
		core.wr(SLOT_CTL_ADDR, 8'h00);
		core.wr(SLOT_COUNT_ADDR, 8'h02);
		repeat (63) @(posedge clock);
		core.wr(SLOT_COUNT_ADDR, 8'h05);
		core.rd(SLOT_COUNT_ADDR, rdv);
		check(rdv === 8'h04, "count write on edge");
		repeat (252) @(posedge clock);
		core.wr(SLOT_CTL_ADDR, 8'h00);
		check(expiryDmaTrigger === 1'b1, "expiry on clearing write");
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv === 8'h40, "set wins over clear");
	endtask : t_collide

	// free running: wraps to all ones after reaching zero
	task automatic t_wrap();
		int k;
		core.wr(PRESCALE_MAX_ADDR, 8'h01);
		core.wr(SLOT_CTL_ADDR, 8'h04);
		core.wr(SLOT_COUNT_ADDR, 8'h02);
		wait_expiry(300, n);
		check(n >= 64 && n <= 200, "free run second slot");
		rdv = COUNT_ZERO;
		k = 0;
		while (rdv === COUNT_ZERO && k < 60)
		begin
			core.rd(SLOT_COUNT_ADDR, rdv);
			k++;
		end
		check(rdv === COUNT_WRAP, "wrap to all ones");
	endtask : t_wrap

	// load, reserved bits, then wake from deep sleep
	task automatic t_wake();
		// large top keeps prescaler edges away from the count write
		core.wr(PRESCALE_MAX_ADDR, 8'h00);
		core.wr(SLOT_CTL_ADDR, 8'hFF);
		core.rd(SLOT_CTL_ADDR, rdv);
		check(rdv === 8'h57, "reserved bits read zero");
		core.wr(SLOT_COUNT_ADDR, 8'h5A);
		core.rd(SLOT_COUNT_ADDR, rdv);
		check(rdv === 8'h5A, "count load");
		@(posedge clock);
		deepSleepWake <= 1'b1;
		@(posedge clock);
		deepSleepWake <= 1'b0;
		t_reset();
		quiet(50);
	endtask : t_wake

	// ==================================================
	// main sequence
	initial
	begin
		rst = 1'b1;
		deepSleepWake = 1'b0;
		slotIrqCpuEnable = 1'b0;
		tickDiv = 1;
		fails = 0;
		num_checks = 0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		#1;
		t_reset();
		for (int r = 0; r < 4; r++)
		begin
			@(posedge clock);
			slotIrqCpuEnable <= r[0];
			t_slot(r[1:0], 8'h01, 64 << ((r == 3) ? 4 : r), 1'b1);
		end
		t_slot(2'b00, 8'h00, 16384, 1'b1);
		tickDiv = 2;
		t_slot(2'b01, 8'h03, 384, 1'b0);
		tickDiv = 1;
		t_collide();
		t_wrap();
		t_wake();
		test_done();
	end

endmodule : mst_timer_test
`default_nettype wire
